// >>> sec_err_ctrl.sv
// Secondary-bus error mask and severity bank
module sec_err_ctrl
    import sec_err_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              pcie_reset_n,
    input  wire logic              global_reset_input,
    input  wire cfg_req_type       cfg_req,
    input  wire logic [DATA_W-1:0] err_detect,
    output cfg_rsp_type            cfg_rsp,
    output err_report_type         err_report
);

    // Mask register state
    logic [DATA_W-1:0] mask_r;
    logic [DATA_W-1:0] mask_nxt;

    // Severity register state
    logic [DATA_W-1:0] sev_r;
    logic [DATA_W-1:0] sev_nxt;

    // Answer and report flops
    cfg_rsp_type       rsp_r;
    cfg_rsp_type       rsp_nxt;
    err_report_type    report_r;

    // Combinational report from the gate
    err_report_type    report_nxt;

    // Any of the three resets clears the bank
    logic              bank_clear;

    // Address decode strobes
    logic              hit_mask;
    logic              hit_sev;
    logic              wr_mask;
    logic              wr_sev;

    // Byte-lane merge, used for both registers
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < BE_W; b++) begin
            if (be[b]) begin
                r[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
            end
        end
        // Reserved bits never take a write
        return r & RW_BITS; // RULE3
    endfunction

    // Combined reset term
    assign bank_clear = !resetn || !pcie_reset_n
                     || global_reset_input; // RULE12

    // Decode of the two offsets
    assign hit_mask = cfg_req.valid
                   && (cfg_req.addr == MASK_OFFSET); // RULE2
    assign hit_sev  = cfg_req.valid
                   && (cfg_req.addr == SEV_OFFSET); // RULE8
    assign wr_mask  = hit_mask && cfg_req.write;
    assign wr_sev   = hit_sev && cfg_req.write;

    // Next mask value
    always_comb begin
        mask_nxt = mask_r;
        // Writing zero to a class unmasks it
        if (wr_mask) begin
            mask_nxt = lane_merge(mask_r, cfg_req.wdata,
                                  cfg_req.be); // RULE6
        end
    end

    // Next severity value
    always_comb begin
        sev_nxt = sev_r;
        // Unused bits are kept only as storage
        if (wr_sev) begin
            sev_nxt = lane_merge(sev_r, cfg_req.wdata,
                                 cfg_req.be); // RULE11
        end
    end

    // Mask register
    always_ff @(posedge clk_sys) begin
        // Defaults mask 12, 10, 9, 7, 3
        if (bank_clear) begin
            mask_r <= MASK_RESET; // RULE5 RULE6 RULE12
        end else begin
            mask_r <= mask_nxt; // RULE4
        end
    end

    // Severity register
    always_ff @(posedge clk_sys) begin
        // Defaults make 12 and 9 fatal
        if (bank_clear) begin
            sev_r <= SEV_RESET; // RULE9 RULE10 RULE12
        end else begin
            sev_r <= sev_nxt;
        end
    end

    // Answer for the configuration access
    always_comb begin
        rsp_nxt       = '0;
        rsp_nxt.ack   = cfg_req.valid;
        rsp_nxt.hit   = hit_mask || hit_sev;
        // Reads return the value before any write
        if (hit_mask && !cfg_req.write) begin
            rsp_nxt.rdata = mask_r & RW_BITS; // RULE3
        end else if (hit_sev && !cfg_req.write) begin
            rsp_nxt.rdata = sev_r & RW_BITS; // RULE3
        end
    end

    // Answer flops; every access gets one ack
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // Gate uses the registers as they stand now,
    // so a write in the detect cycle does not apply
    err_class_gate u_gate (
        .detect (err_detect),
        .mask   (mask_r), // RULE14
        .sev    (sev_r),
        .report (report_nxt)
    );

    // Report flops; one-cycle pulses, never recalled
    always_ff @(posedge clk_sys) begin
        // Nothing reported across a reset
        if (bank_clear) begin
            report_r <= '0;
        end else begin
            report_r <= report_nxt; // RULE1 RULE14
        end
    end

    // Outputs straight from flops
    assign cfg_rsp    = rsp_r;
    assign err_report = report_r;

    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!resetn);

    // Full-word write to the mask
    sequence s_mask_write;
        cfg_req.valid && cfg_req.write
        && cfg_req.addr == MASK_OFFSET
        && cfg_req.be == 4'hF
        && pcie_reset_n && !global_reset_input;
    endsequence

    // Full-word write to the severity
    sequence s_sev_write;
        cfg_req.valid && cfg_req.write
        && cfg_req.addr == SEV_OFFSET
        && cfg_req.be == 4'hF
        && pcie_reset_n && !global_reset_input;
    endsequence

    // Clean cycle after a clear
    sequence s_bank_reset;
        (!pcie_reset_n || global_reset_input) ##1 !bank_clear;
    endsequence

    a_mask_default: assert property ( // RULE2
        s_bank_reset |-> mask_r == MASK_RESET
    ) else $error("mask not at default after reset");

    a_sev_default: assert property ( // RULE8
        s_bank_reset |-> sev_r == SEV_RESET
    ) else $error("severity not at default after reset");

    a_reserved_zero: assert property ( // RULE3
        rsp_r.rdata[31:14] == '0 && !rsp_r.rdata[4]
        && !rsp_r.rdata[0]
    ) else $error("reserved bits read nonzero");

    a_mask_store: assert property ( // RULE4
        s_mask_write |=> mask_r == ($past(cfg_req.wdata) & RW_BITS)
    ) else $error("mask write not stored");

    a_sev_store: assert property ( // RULE11
        s_sev_write |=> sev_r == ($past(cfg_req.wdata) & RW_BITS)
    ) else $error("severity write not stored");

    a_masked_silent: assert property ( // RULE1
        !bank_clear ##1 !bank_clear
        |-> (err_report.status_set & $past(mask_r)) == '0
    ) else $error("masked class reached status");

    a_unused_silent: assert property ( // RULE4
        (err_detect & ~UNUSED_BITS) == '0 && !bank_clear
        |=> !err_report.log_load && !err_report.msg_fatal
        && !err_report.msg_nonfatal
    ) else $error("storage-only class produced a report");

    a_fatal_pick: assert property ( // RULE7
        (|(err_detect & FUNC_BITS & ~mask_r & sev_r)) && !bank_clear
        |=> err_report.msg_fatal && err_report.first_upd
    ) else $error("fatal class gave no fatal message");

    a_nonfatal_pick: assert property ( // RULE7
        (|(err_detect & FUNC_BITS & ~mask_r & ~sev_r))
        && !bank_clear
        |=> err_report.msg_nonfatal && err_report.log_load
    ) else $error("nonfatal class gave no nonfatal message");

    a_detect_snapshot: assert property ( // RULE14
        s_mask_write ##0 (|(err_detect & FUNC_BITS & ~mask_r))
        |=> err_report.status_set
            == $past(err_detect & FUNC_BITS & ~mask_r)
    ) else $error("write in detect cycle altered report");

    a_access_ack: assert property (
        cfg_req.valid |=> cfg_rsp.ack ##1 !$past(cfg_req.valid)
            || cfg_rsp.ack
    ) else $error("access not acknowledged");

    // A functional class that survives the mask
    sequence s_live_detect;
        (|(err_detect & FUNC_BITS & ~mask_r)) && !bank_clear;
    endsequence

    // Status follows the classes live at detection
    a_status_exact: assert property ( // RULE1
        s_live_detect |=> err_report.status_set
            == $past(err_detect & FUNC_BITS & ~mask_r)
    ) else $error("status bits differ from live classes");

    // Reset pattern per class of the mask
    a_mask_classes: assert property ( // RULE5 RULE6
        s_bank_reset |-> mask_r[BIT_SYSTEM_ERR]
        && !mask_r[BIT_PARITY_SEEN] && !mask_r[BIT_RESP_ABORT]
    ) else $error("mask classes wrong after reset");

    // Reset pattern per class of the severity
    a_sev_classes: assert property ( // RULE9 RULE10
        s_bank_reset |-> sev_r[BIT_SYSTEM_ERR] && sev_r[BIT_ADDR_PARITY]
        && !sev_r[BIT_PARITY_SEEN] && !sev_r[BIT_RESP_ABORT]
    ) else $error("severity classes wrong after reset");

    // Zero written to a functional mask bit unmasks it
    a_unmask_zero: assert property ( // RULE6
        s_mask_write
        |=> (mask_r & FUNC_BITS & ~$past(cfg_req.wdata)) == '0
    ) else $error("zero write left class masked");

    // Mask moves only on a write or a reset
    a_mask_hold: assert property ( // RULE2
        !wr_mask && !bank_clear |=> $stable(mask_r)
    ) else $error("mask changed without a write");

    // Severity moves only on a write or a reset
    a_sev_hold: assert property ( // RULE8
        !wr_sev && !bank_clear |=> $stable(sev_r)
    ) else $error("severity changed without a write");

    // Any clear source empties the report
    a_reset_quiet: assert property ( // RULE12
        bank_clear |=> err_report == '0
    ) else $error("report survived a reset");

    // No surviving class, no message, log or pointer
    a_quiet_empty: assert property ( // RULE1
        err_report.status_set == '0
        |-> !err_report.msg_fatal && !err_report.msg_nonfatal
        && !err_report.log_load && !err_report.first_upd
    ) else $error("report without a status bit");

    // Pointer names the lowest reported class
    a_ptr_lowest: assert property ( // RULE1
        err_report.first_upd
        |-> err_report.status_set[err_report.first_ptr]
        && (err_report.status_set
            & ((32'h1 << err_report.first_ptr) - 32'h1)) == '0
    ) else $error("first pointer not lowest class");

    // Fatal message only for a class marked fatal
    a_fatal_only: assert property ( // RULE7
        err_report.msg_fatal |-> (err_report.status_set & $past(sev_r)) != '0
    ) else $error("fatal message for nonfatal class");

    // Nonfatal message only for a class marked nonfatal
    a_nonfatal_only: assert property ( // RULE7
        err_report.msg_nonfatal
        |-> (err_report.status_set & ~$past(sev_r)) != '0
    ) else $error("nonfatal message for fatal class");

    // An answer only follows a request
    a_ack_source: assert property (
        cfg_rsp.ack |-> $past(cfg_req.valid)
    ) else $error("answer without a request");

endmodule

// >>> sec_err_pkg.sv
// Notes on behaviour
// (RULE1) Masked class: no status, message, log, pointer
// (RULE2) Mask at 130h, resets to 0000 17A8h
// (RULE3) Bits 31:14, 4, 0 reserved, read zero
// (RULE4) Mask bits 13,8,6,5,1 stored, no effect
// (RULE5) Reset masks classes 12, 10, 9, 7, 3
// (RULE6) Classes 11, 2 unmasked; zero unmasks
// (RULE7) Severity one fatal, zero nonfatal message
// (RULE8) Severity at 134h, resets to 0000 1340h
// (RULE9) Reset makes classes 12 and 9 fatal
// (RULE10) Reset makes 11,10,7,3,2 nonfatal
// (RULE11) Severity bits 13,8,6,5,1 stored, no effect
// (RULE12) Any of three resets restores defaults
// (RULE13) Software clears status by writing one
// (RULE14) Values at detection apply; no retraction
package sec_err_pkg;

    // Register geometry
    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 12;
    localparam int          BE_W        = 4;
    localparam int          PTR_W       = 5;
    localparam int          BYTE_W      = 8;

    // Extended configuration offsets
    localparam logic [11:0] MASK_OFFSET = 12'h130;
    localparam logic [11:0] SEV_OFFSET  = 12'h134;

    // Reset values
    localparam logic [31:0] MASK_RESET  = 32'h0000_17A8;
    localparam logic [31:0] SEV_RESET   = 32'h0000_1340;

    // Storable bits: 13..5 and 3..1
    localparam logic [31:0] RW_BITS     = 32'h0000_3FEE;
    // Bits that steer reporting: 12..9, 7, 3, 2
    localparam logic [31:0] FUNC_BITS   = 32'h0000_1E8C;
    // Storage-only bits: 13, 8, 6, 5, 1
    localparam logic [31:0] UNUSED_BITS = 32'h0000_2162;

    // Error class positions
    localparam int BIT_SYSTEM_ERR   = 12;
    localparam int BIT_PARITY_SEEN  = 11;
    localparam int BIT_ADDR_PARITY  = 9;
    localparam int BIT_RESP_ABORT   = 2;

    // Configuration request
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   be;
        logic [DATA_W-1:0] wdata;
    } cfg_req_type;

    // Configuration answer
    typedef struct packed {
        logic              ack;
        logic              hit;
        logic [DATA_W-1:0] rdata;
    } cfg_rsp_type;

    // Qualified error report
    typedef struct packed {
        logic [DATA_W-1:0] status_set;
        logic              msg_fatal;
        logic              msg_nonfatal;
        logic              log_load;
        logic              first_upd;
        logic [PTR_W-1:0]  first_ptr;
    } err_report_type;

endpackage

// >>> err_class_gate.sv
// Qualifies raw error detections against mask and severity
module err_class_gate
    import sec_err_pkg::*;
(
    input  wire logic [DATA_W-1:0] detect,
    input  wire logic [DATA_W-1:0] mask,
    input  wire logic [DATA_W-1:0] sev,
    output err_report_type         report
);

    // Per-class survivors of the mask
    logic [DATA_W-1:0] live;

    // Lowest live class wins the pointer
    function automatic logic [PTR_W-1:0] lowest_set(
        input logic [DATA_W-1:0] v
    );
        logic [PTR_W-1:0] p;
        p = '0;
        for (int k = DATA_W - 1; k >= 0; k--) begin
            if (v[k]) begin
                p = PTR_W'(k);
            end
        end
        return p;
    endfunction

    // One gate per class; storage-only bits never pass
    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_class
            // Masked class is dropped entirely
            assign live[i] = detect[i] & FUNC_BITS[i]
                           & ~mask[i]; // RULE1 RULE4
        end
    endgenerate

    // Build the report from surviving classes
    always_comb begin
        report              = '0;
        report.status_set   = live; // RULE1
        // Severity picks the message kind
        report.msg_fatal    = |(live & sev); // RULE7
        report.msg_nonfatal = |(live & ~sev); // RULE7
        report.log_load     = |live; // RULE1
        report.first_upd    = |live; // RULE1
        report.first_ptr    = lowest_set(live);
    end

endmodule

// >>> cfg_host.sv
// Stands in for configuration software on the extended config port
module cfg_host
    import sec_err_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire cfg_rsp_type cfg_rsp,
    output cfg_req_type      cfg_req
);
    timeunit 1ns;
    timeprecision 1ps;

    cfg_rsp_type rsp_r;  // Answer of the last access

    // Idle port from time zero
    initial begin
        cfg_req = '0;
    end

    // One access through the given byte lanes; request stands until the taking edge
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [BE_W-1:0] be,
                          input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        #1;
        cfg_req = '{1'b1, wr, a, be, d};
        @(posedge clk_sys);
        #1;
        // Answer stands one cycle only, so it is taken here
        rsp_r = cfg_rsp;
        cfg_req = '0;
    endtask

    // Status clears by writing ones; that register lives outside the bank
    task automatic clear_status(input logic [DATA_W-1:0] bits);
        access(1'b1, 12'h12C, 4'hF, bits);
    endtask
endmodule

// >>> test_secondary_bus_error_mask_severity.sv
module test_secondary_bus_error_mask_severity
    import sec_err_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk_sys;             // 250 MHz
    logic              resetn;              // Power-on reset
    logic              pcie_reset_n;        // Fundamental reset
    logic              global_reset_input;  // Global reset, high
    cfg_req_type       cfg_req;             // From software model
    cfg_rsp_type       cfg_rsp;             // Config answer
    logic [DATA_W-1:0] err_detect;          // Raw class pulses
    err_report_type    err_report;          // Qualified report
    logic [DATA_W-1:0] sv;                  // Severity under test
    int                num_errors = 0;
    int                cmp_count = 0;

    sec_err_ctrl sec_err_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
        .pcie_reset_n(pcie_reset_n),
        .global_reset_input(global_reset_input), .cfg_req(cfg_req),
        .err_detect(err_detect), .cfg_rsp(cfg_rsp),
        .err_report(err_report));

    cfg_host cfg_host_i (.clk_sys(clk_sys), .cfg_rsp(cfg_rsp),
        .cfg_req(cfg_req));

    // Free-running clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Register read compared with ack, claim flag and data
    task automatic rd(input logic [ADDR_W-1:0] a, input logic h,
                      input logic [DATA_W-1:0] exp);
        cfg_host_i.access(1'b0, a, 4'hF, '0);
        cmp_count++;
        if (cfg_host_i.rsp_r !== {1'b1, h, exp}) begin
            num_errors++;
            $display("[FAIL] %0t read %h got %h", $time, a,
                     cfg_host_i.rsp_r);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        cfg_host_i.access(1'b1, a, 4'hF, d);
    endtask

    // Write through selected byte lanes only
    task automatic wr_lanes(input logic [ADDR_W-1:0] a,
                            input logic [BE_W-1:0] be,
                            input logic [DATA_W-1:0] d);
        cfg_host_i.access(1'b1, a, be, d);
    endtask

    // One detection pulse, report expected one edge later
    task automatic fire(input logic [DATA_W-1:0] det, st,
                        input logic f, nf);
        err_report_type e;
        logic [PTR_W-1:0] p;
        p = '0;
        // Pointer names the lowest surviving class
        for (int i = 13; i >= 0; i--) begin
            if (st[i]) p = PTR_W'(i);
        end
        e = '{st, f, nf, |st, |st, p};
        @(posedge clk_sys);
        #1;
        err_detect = det;
        @(posedge clk_sys);
        #1;
        err_detect = '0;
        cmp_count++;
        if (err_report !== e) begin
            num_errors++;
            $display("[FAIL] %0t report %h got %h", $time, det, err_report);
        end
    endtask

    // One-cycle pulse on reset source k
    task automatic pulse_rst(input int k);
        @(posedge clk_sys);
        #1;
        if (k == 0) resetn = 1'b0;
        else if (k == 1) pcie_reset_n = 1'b0;
        else global_reset_input = 1'b1;
        @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        pcie_reset_n = 1'b1;
        global_reset_input = 1'b0;
    endtask

    // Hang guard, well past the 114 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        pcie_reset_n = 1'b1;
        global_reset_input = 1'b0;
        err_detect = '0;
        repeat (16) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        rd(MASK_OFFSET, 1'b1, 32'h0000_17A8);
        rd(SEV_OFFSET, 1'b1, 32'h0000_1340);
        rd(12'h138, 1'b0, '0);
        fire(RW_BITS, 32'h0000_0804, 1'b0, 1'b1);
        $display("defaults done");
        wr(MASK_OFFSET, 32'hFFFF_FFFF);
        wr(SEV_OFFSET, 32'hFFFF_FFFF);
        rd(MASK_OFFSET, 1'b1, 32'h0000_3FEE);
        rd(SEV_OFFSET, 1'b1, 32'h0000_3FEE);
        fire(32'hFFFF_FFFF, '0, 1'b0, 1'b0);
        $display("access done");
        // Storage-only mask bits left set must not hide anything
        wr(MASK_OFFSET, UNUSED_BITS);
        for (int k = 0; k < 2; k++) begin
            sv = k ? UNUSED_BITS : 32'hFFFF_FFFF;
            wr(SEV_OFFSET, sv);
            for (int i = 0; i < 14; i++) begin
                if (FUNC_BITS[i]) begin
                    fire(1 << i, 1 << i, sv[i], !sv[i]);
                end
            end
        end
        fire(UNUSED_BITS, '0, 1'b0, 1'b0);
        $display("classes done");
        // Mask written in the detection cycle applies only afterwards
        fork
            wr(MASK_OFFSET, 32'hFFFF_FFFF);
            fire(32'h4, 32'h4, 1'b0, 1'b1);
        join
        fire(32'h4, '0, 1'b0, 1'b0);
        $display("timing done");
        // Zero through byte lane 1 only unmasks classes 12..9
        wr_lanes(MASK_OFFSET, 4'h2, '0);
        rd(MASK_OFFSET, 1'b1, 32'h0000_00EE);
        fire(32'h0000_1000, 32'h0000_1000, 1'b0, 1'b1);
        // Clearing status elsewhere leaves the bank alone
        cfg_host_i.clear_status(32'h0000_0804);
        rd(MASK_OFFSET, 1'b1, 32'h0000_00EE);
        $display("lanes done");
        for (int k = 0; k < 3; k++) begin
            wr(MASK_OFFSET, '0);
            wr(SEV_OFFSET, '0);
            pulse_rst(k);
            rd(MASK_OFFSET, 1'b1, MASK_RESET);
            rd(SEV_OFFSET, 1'b1, SEV_RESET);
        end
        $display("resets done");
        end_of_test();
    end
endmodule
